// ### rtl/exc_pkg.sv
// constants, types and field layout of the exception cause and return address block
package exc_pkg;

  // -------------------------------------------------------------------
  // register map
  // -------------------------------------------------------------------
  localparam logic [31:0] CAUSE_ADDR = 32'h0000_0000;
  localparam logic [31:0] EPC_ADDR = 32'h0000_0004;
  localparam logic [31:0] CTRL_ADDR = 32'h0000_0008;
  localparam logic [31:0] INFO_ADDR = 32'h0000_000c;

  // -------------------------------------------------------------------
  // field positions
  // -------------------------------------------------------------------
  localparam int DS_POS = 31;
  localparam int CE_LSB = 28;
  localparam int IP_LSB = 8;
  localparam int EXC_LSB = 2;
  localparam int CTRL_IE_POS = 0;
  localparam int CTRL_EXL_POS = 1;
  localparam int CTRL_ERL_POS = 2;
  localparam int CTRL_IM_LSB = 8;
  localparam int INFO_COMPACT_POS = 0;
  localparam int INFO_IRQ_POS = 1;

  // -------------------------------------------------------------------
  // reset values and timing
  // -------------------------------------------------------------------
  localparam logic [31:0] EPC_RST = 32'h0000_0000;
  localparam logic [4:0] CODE_RST = 5'h00;
  localparam logic [7:0] IM_RST = 8'h00;
  localparam logic IE_RST = 1'b0;
  localparam logic EXL_RST = 1'b0;
  localparam logic ERL_RST = 1'b1;
  localparam logic [2:0] PIN_SETTLE_CYCLES = 3'h4;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // -------------------------------------------------------------------
  // exception codes
  // -------------------------------------------------------------------
  typedef enum logic [4:0] {
    EXC_INTERRUPT = 5'h00,
    EXC_TLB_MODIFIED = 5'h01,
    EXC_TLB_REFILL_LOAD = 5'h02,
    EXC_TLB_REFILL_STORE = 5'h03,
    EXC_ADDR_ERR_LOAD = 5'h04,
    EXC_ADDR_ERR_STORE = 5'h05,
    EXC_BUS_ERR_FETCH = 5'h06,
    EXC_BUS_ERR_DATA = 5'h07,
    EXC_SYSCALL = 5'h08,
    EXC_BREAKPOINT = 5'h09,
    EXC_RESERVED_INSTR = 5'h0a,
    EXC_COP_UNUSABLE = 5'h0b,
    EXC_OVERFLOW = 5'h0c,
    EXC_TRAP = 5'h0d,
    EXC_WATCH = 5'h17
  } exc_code_t;

  function automatic logic code_legal(input logic [4:0] c);
    return (c <= EXC_TRAP) || (c == EXC_WATCH);
  endfunction : code_legal

endpackage : exc_pkg

// ### rtl/reg_access_if.sv
// register access strobes between the bus slave and the register file
`timescale 1ns/1ps
interface reg_access_if;
  logic wr_en;
  logic [31:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  logic wr_ok;
  logic rd_en;
  logic [31:0] rd_addr;
  logic [31:0] rd_data;
  logic rd_ok;

  modport slave_side (
    output wr_en, wr_addr, wr_data, wr_strb, rd_en, rd_addr,
    input wr_ok, rd_data, rd_ok
  );
  modport regs_side (
    input wr_en, wr_addr, wr_data, wr_strb, rd_en, rd_addr,
    output wr_ok, rd_data, rd_ok
  );
endinterface : reg_access_if

// ### rtl/pin_sync3.sv
// three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
module pin_sync3 #(
  parameter int WIDTH = 6
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic clk_en,
  input wire logic [WIDTH-1:0] pin_in,
  output logic [WIDTH-1:0] pin_out
);
  if (WIDTH < 1) begin : g_bad_width
    $error("pin_sync3 needs WIDTH of at least 1");
  end

  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s3;
    logic [WIDTH-1:0] out;
  } sync_state_t;

  sync_state_t q, d;
  logic [WIDTH-1:0] differ;

  always_comb begin
    d = q;
    d.s1 = pin_in;
    d.s2 = q.s1;
    d.s3 = q.s2;
    // output follows only once second and third stage agree
    differ = q.s2 ^ q.s3;
    d.out = (q.s3 & ~differ) | (q.out & differ);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q <= '0;
    end else if (clk_en) begin
      q <= d;
    end
  end

  assign pin_out = q.out;
endmodule : pin_sync3

// ### rtl/reg_axil_slave.sv
// axi4-lite slave turning bus transfers into register strobes
`timescale 1ns/1ps
module reg_axil_slave (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic clk_en,
  input wire logic [31:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [31:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  reg_access_if.slave_side bus
);
  import exc_pkg::*;

  typedef struct packed {
    logic aw_have;
    logic [31:0] awaddr;
    logic w_have;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic ar_have;
    logic [31:0] araddr;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic awready;
    logic wready;
    logic arready;
  } slave_state_t;

  slave_state_t q, d;

  assign bus.wr_en = q.aw_have && q.w_have && !q.bvalid;
  assign bus.wr_addr = q.awaddr;
  assign bus.wr_data = q.wdata;
  assign bus.wr_strb = q.wstrb;
  assign bus.rd_en = q.ar_have && !q.rvalid;
  assign bus.rd_addr = q.araddr;

  always_comb begin
    d = q;
    // -------------------------------------------------------------------
    // write path: address and data in either order
    // -------------------------------------------------------------------
    if (awvalid && q.awready) begin
      d.aw_have = 1'b1;
      d.awaddr = awaddr;
    end
    if (wvalid && q.wready) begin
      d.w_have = 1'b1;
      d.wdata = wdata;
      d.wstrb = wstrb;
    end
    if (q.bvalid && bready) begin
      d.bvalid = 1'b0;
    end
    if (bus.wr_en) begin
      d.bvalid = 1'b1;
      d.bresp = bus.wr_ok ? RESP_OKAY : RESP_SLVERR;
      d.aw_have = 1'b0;
      d.w_have = 1'b0;
    end
    // -------------------------------------------------------------------
    // read path
    // -------------------------------------------------------------------
    if (arvalid && q.arready) begin
      d.ar_have = 1'b1;
      d.araddr = araddr;
    end
    if (q.rvalid && rready) begin
      d.rvalid = 1'b0;
    end
    if (bus.rd_en) begin
      d.rvalid = 1'b1;
      d.rdata = bus.rd_ok ? bus.rd_data : 32'h0000_0000;
      d.rresp = bus.rd_ok ? RESP_OKAY : RESP_SLVERR;
      d.ar_have = 1'b0;
    end
    // one transfer of each kind in flight
    d.awready = !d.aw_have && !d.bvalid;
    d.wready = !d.w_have && !d.bvalid;
    d.arready = !d.ar_have && !d.rvalid;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q <= '0;
    end else if (clk_en) begin
      q <= d;
    end
  end

  assign awready = q.awready;
  assign wready = q.wready;
  assign bvalid = q.bvalid;
  assign bresp = q.bresp;
  assign arready = q.arready;
  assign rvalid = q.rvalid;
  assign rdata = q.rdata;
  assign rresp = q.rresp;
endmodule : reg_axil_slave

// ### rtl/exc_cause_epc.sv
// exception cause and return address registers of the system coprocessor
`timescale 1ns/1ps
module exc_cause_epc (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic clk_en,
  input wire logic [31:0] s_axil_awaddr,
  input wire logic s_axil_awvalid,
  output logic s_axil_awready,
  input wire logic [31:0] s_axil_wdata,
  input wire logic [3:0] s_axil_wstrb,
  input wire logic s_axil_wvalid,
  output logic s_axil_wready,
  output logic [1:0] s_axil_bresp,
  output logic s_axil_bvalid,
  input wire logic s_axil_bready,
  input wire logic [31:0] s_axil_araddr,
  input wire logic s_axil_arvalid,
  output logic s_axil_arready,
  output logic [31:0] s_axil_rdata,
  output logic [1:0] s_axil_rresp,
  output logic s_axil_rvalid,
  input wire logic s_axil_rready,
  input wire logic exc_valid,
  input wire logic [4:0] exc_code,
  input wire logic [31:0] exc_pc,
  input wire logic [31:0] exc_branch_pc,
  input wire logic exc_in_delay_slot,
  input wire logic exc_after_extend,
  input wire logic exc_isa16,
  input wire logic [1:0] exc_cop_num,
  input wire logic [31:0] count_value,
  input wire logic [31:0] compare_value,
  input wire logic [4:0] int_req,
  input wire logic compact_isa_enable_pin,
  output logic interrupt_request,
  output logic exception_level,
  output logic compact_isa_enabled
);
  import exc_pkg::*;

  typedef struct packed {
    logic delay_slot_flag;
    logic [1:0] cop_num;
    logic [7:0] interrupt_pending;
    logic [4:0] exception_code;
    logic [31:0] epc;
    logic global_interrupt_enable;
    logic exception_level;
    logic error_level;
    logic [7:0] interrupt_mask;
    logic compact_en;
    logic sampled;
    logic [2:0] settle_cnt;
    logic irq;
  } core_state_t;

  core_state_t q, d;
  reg_access_if bus ();
  logic [5:0] sync_out;
  logic [4:0] int_sync;
  logic compact_sync;
  logic exc_take;
  logic slot;
  logic [31:0] restart;
  logic [31:0] cause_word;
  logic [31:0] ctrl_word;
  logic [31:0] ctrl_new;
  logic [31:0] info_word;

  function automatic logic [31:0] byte_merge(input logic [31:0] old_v,
                                              input logic [31:0] new_v,
                                              input logic [3:0] strb);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[8*i +: 8] = new_v[8*i +: 8];
      end
    end
    return r;
  endfunction : byte_merge

  // -------------------------------------------------------------------
  // bus slave and input synchronisers
  // -------------------------------------------------------------------
  reg_axil_slave u_slave (
    .aclk(aclk),
    .aresetn(aresetn),
    .clk_en(clk_en),
    .awaddr(s_axil_awaddr),
    .awvalid(s_axil_awvalid),
    .awready(s_axil_awready),
    .wdata(s_axil_wdata),
    .wstrb(s_axil_wstrb),
    .wvalid(s_axil_wvalid),
    .wready(s_axil_wready),
    .bresp(s_axil_bresp),
    .bvalid(s_axil_bvalid),
    .bready(s_axil_bready),
    .araddr(s_axil_araddr),
    .arvalid(s_axil_arvalid),
    .arready(s_axil_arready),
    .rdata(s_axil_rdata),
    .rresp(s_axil_rresp),
    .rvalid(s_axil_rvalid),
    .rready(s_axil_rready),
    .bus(bus.slave_side)
  );

  pin_sync3 #(
    .WIDTH(6)
  ) u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .clk_en(clk_en),
    .pin_in({compact_isa_enable_pin, int_req}),
    .pin_out(sync_out)
  );

  assign int_sync = sync_out[4:0];
  assign compact_sync = sync_out[5];

  // -------------------------------------------------------------------
  // register words and read decode
  // -------------------------------------------------------------------
  always_comb begin
    cause_word = 32'h0000_0000;
    cause_word[DS_POS] = q.delay_slot_flag;
    cause_word[CE_LSB +: 2] = q.cop_num;
    cause_word[IP_LSB +: 8] = q.interrupt_pending;
    cause_word[EXC_LSB +: 5] = q.exception_code;
    ctrl_word = 32'h0000_0000;
    ctrl_word[CTRL_IE_POS] = q.global_interrupt_enable;
    ctrl_word[CTRL_EXL_POS] = q.exception_level;
    ctrl_word[CTRL_ERL_POS] = q.error_level;
    ctrl_word[CTRL_IM_LSB +: 8] = q.interrupt_mask;
    info_word = 32'h0000_0000;
    info_word[INFO_COMPACT_POS] = q.compact_en;
    info_word[INFO_IRQ_POS] = q.irq;
  end

  always_comb begin
    bus.rd_ok = 1'b1;
    unique case (bus.rd_addr)
      CAUSE_ADDR: bus.rd_data = cause_word;
      EPC_ADDR: bus.rd_data = q.epc;
      CTRL_ADDR: bus.rd_data = ctrl_word;
      INFO_ADDR: bus.rd_data = info_word;
      default: begin
        bus.rd_data = 32'h0000_0000;
        bus.rd_ok = 1'b0;
      end
    endcase
  end

  assign bus.wr_ok = (bus.wr_addr == CAUSE_ADDR) || (bus.wr_addr == EPC_ADDR) ||
                     (bus.wr_addr == CTRL_ADDR) || (bus.wr_addr == INFO_ADDR);

  // -------------------------------------------------------------------
  // next state
  // -------------------------------------------------------------------
  always_comb begin
    d = q;
    ctrl_new = byte_merge(ctrl_word, bus.wr_data, bus.wr_strb);
    exc_take = exc_valid && code_legal(exc_code);
    slot = exc_in_delay_slot || (q.compact_en && exc_isa16 && exc_after_extend);
    restart = slot ? exc_branch_pc : exc_pc;

    if (!q.sampled) begin
      if (q.settle_cnt == PIN_SETTLE_CYCLES) begin
        d.compact_en = compact_sync;
        d.sampled = 1'b1;
      end else begin
        d.settle_cnt = q.settle_cnt + 3'h1;
      end
    end

    d.interrupt_pending[7] = (count_value == compare_value);
    d.interrupt_pending[6:2] = int_sync;

    if (bus.wr_en) begin
      if (bus.wr_addr == CAUSE_ADDR && bus.wr_strb[IP_LSB / 8]) begin
        d.interrupt_pending[1:0] = bus.wr_data[IP_LSB +: 2];
      end
      if (bus.wr_addr == EPC_ADDR) begin
        d.epc = byte_merge(q.epc, bus.wr_data, bus.wr_strb);
      end
      if (bus.wr_addr == CTRL_ADDR) begin
        d.global_interrupt_enable = ctrl_new[CTRL_IE_POS];
        d.exception_level = ctrl_new[CTRL_EXL_POS];
        d.error_level = ctrl_new[CTRL_ERL_POS];
        d.interrupt_mask = ctrl_new[CTRL_IM_LSB +: 8];
      end
    end

    // exception recording wins over a software write in the same cycle, except a return address write while already at exception level
    if (exc_take) begin
      d.exception_code = exc_code;
      d.delay_slot_flag = slot;
      if (exc_code == EXC_COP_UNUSABLE) begin
        d.cop_num = exc_cop_num;
      end
      if (!q.exception_level) begin
        d.epc = q.compact_en ? {restart[31:1], exc_isa16} : restart;
      end
      d.exception_level = 1'b1;
    end

    d.irq = q.global_interrupt_enable && !q.exception_level && !q.error_level &&
            |(q.interrupt_pending & q.interrupt_mask);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q <= '0;
      q.exception_code <= CODE_RST;
      q.epc <= EPC_RST;
      q.global_interrupt_enable <= IE_RST;
      q.exception_level <= EXL_RST;
      q.error_level <= ERL_RST;
      q.interrupt_mask <= IM_RST;
    end else if (clk_en) begin
      q <= d;
    end
  end

  assign interrupt_request = q.irq;
  assign exception_level = q.exception_level;
  assign compact_isa_enabled = q.compact_en;

  // -------------------------------------------------------------------
  // checks
  // -------------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_epc_held: assert property (clk_en && exc_take && q.exception_level
    |=> $stable(q.epc)) else $error("return address overwritten at exception level");

  a_epc_plain: assert property (clk_en && exc_take && !q.exception_level && !q.compact_en
    |=> q.epc == $past(exc_in_delay_slot ? exc_branch_pc : exc_pc))
    else $error("plain return address wrong");

  a_epc_slot: assert property (clk_en && exc_take && !q.exception_level && exc_in_delay_slot
    |=> q.epc[31:1] == $past(exc_branch_pc[31:1]) && q.delay_slot_flag)
    else $error("slot fault not pointed at branch");

  a_isa_bit: assert property (clk_en && exc_take && !q.exception_level && q.compact_en
    |=> q.epc[0] == $past(exc_isa16)) else $error("isa mode bit wrong");

  a_code_legal: assert property (code_legal(q.exception_code))
    else $error("reserved exception code recorded");

  a_timer_pend: assert property (clk_en && count_value == compare_value
    |=> q.interrupt_pending[7]) else $error("timer match not pending");

  a_cause_ro: assert property (clk_en && bus.wr_en && bus.wr_addr == CAUSE_ADDR && !exc_take
    |=> $stable({q.delay_slot_flag, q.cop_num, q.exception_code}))
    else $error("read-only cause field changed by write");

  a_soft_pend: assert property (clk_en && bus.wr_en && bus.wr_addr == CAUSE_ADDR && bus.wr_strb[1]
    |=> q.interrupt_pending[1:0] == $past(bus.wr_data[9:8])) else $error("software pending lost");

  a_cop_field: assert property (clk_en && exc_take && exc_code == EXC_COP_UNUSABLE
    |=> q.cop_num == $past(exc_cop_num)) else $error("coprocessor number not recorded");

  a_irq_gate: assert property (clk_en && (q.exception_level || q.error_level)
    |=> !interrupt_request) else $error("interrupt raised while blocked");

  a_irq_raise: assert property (clk_en && q.global_interrupt_enable
    && !q.exception_level && !q.error_level && |(q.interrupt_pending & q.interrupt_mask)
    |=> interrupt_request) else $error("enabled interrupt not raised");

  a_line_mirror: assert property (clk_en
    |=> q.interrupt_pending[6:2] == $past(int_sync)) else $error("interrupt lines not mirrored");

  a_code_write: assert property (clk_en && exc_take
    |=> q.exception_code == $past(exc_code)) else $error("exception code not recorded");

  a_plain_flag: assert property (clk_en && exc_take && !q.compact_en
    |=> q.delay_slot_flag == $past(exc_in_delay_slot)) else $error("slot flag wrong");

  a_extend_slot: assert property (clk_en && exc_take && !q.exception_level
    && q.compact_en && exc_isa16 && exc_after_extend
    |=> q.epc == {$past(exc_branch_pc[31:1]), 1'b1} && q.delay_slot_flag)
    else $error("extend prefix fault not pointed at prefix");

  a_compact_hold: assert property (clk_en && q.sampled
    |=> $stable(q.compact_en)) else $error("compact enable changed after sampling");

  // clock enable low freezes every register of this level
  a_frozen_state: assert property (!clk_en |=> $stable(q))
    else $error("state moved with clock enable low");
endmodule : exc_cause_epc

// ### testbench/pipe_model.sv
// pipeline, timer and interrupt line model driving the exception block
`timescale 1ns/1ps
module pipe_model (
  input wire logic aclk,
  output logic exc_valid,
  output logic [4:0] exc_code,
  output logic [31:0] exc_pc,
  output logic [31:0] exc_branch_pc,
  output logic exc_in_delay_slot,
  output logic exc_after_extend,
  output logic exc_isa16,
  output logic [1:0] exc_cop_num,
  output logic [31:0] count_value,
  output logic [31:0] compare_value,
  output logic [4:0] int_req
);
  logic count_run = 1'b1;
  initial begin
    {exc_valid, exc_code, exc_pc, exc_branch_pc, exc_in_delay_slot, exc_after_extend} = '0;
    {exc_isa16, exc_cop_num, count_value, int_req} = '0;
    compare_value = 32'hffff_0000;
  end
  always @(posedge aclk) begin
    if (count_run) count_value <= count_value + 32'h1;
  end
  // one report pulse; fields but the coprocessor number are scrambled once it is over
  task automatic raise(input logic [4:0] c, input logic [31:0] p, input logic [31:0] b,
                       input logic [2:0] f);
    @(posedge aclk);
    exc_valid <= 1'b1;
    exc_code <= c;
    exc_pc <= p;
    exc_branch_pc <= b;
    {exc_in_delay_slot, exc_after_extend, exc_isa16} <= f;
    exc_cop_num <= 2'h2;
    @(posedge aclk);
    exc_valid <= 1'b0;
    exc_code <= ~c;
    exc_pc <= ~p;
    exc_branch_pc <= ~b;
    {exc_in_delay_slot, exc_after_extend, exc_isa16} <= ~f;
    @(posedge aclk);
  endtask : raise
  task automatic irq(input logic [4:0] v);
    @(posedge aclk);
    int_req <= v;
  endtask : irq
  // hit stops the count on the compare value, otherwise it runs away from it
  task automatic timer(input logic hit);
    @(posedge aclk);
    count_run <= !hit;
    compare_value <= hit ? count_value + 32'h1 : count_value - 32'h10;
  endtask : timer
endmodule : pipe_model

// ### testbench/exc_cause_epc_bench.sv
// self-checking bench of the exception cause and return address block
`timescale 1ns/1ps
module exc_cause_epc_bench;
  import exc_pkg::*;
  logic aclk, aresetn, pin, ce, awvalid, wvalid, bready, arvalid, rready;
  logic [31:0] awaddr, wdata, araddr, rd_v, p;
  logic [3:0] wstrb;
  logic [4:0] c;
  logic [31:0] ctl [5] = '{32'h0101, 32'h0201, 32'h0100, 32'h0103, 32'h0105};
  wire logic awready, wready, bvalid, arready, rvalid, irq_o, exl_o, cmp_o;
  wire logic e_v, e_ds, e_ext, e_i16;
  wire logic [1:0] bresp, rresp, e_cop;
  wire logic [31:0] rdata, e_pc, e_bpc, cnt, cmpv;
  wire logic [4:0] e_code, ireq;
  int error_cnt = 0;
  int cmp_count = 0;

  exc_cause_epc i_exc_cause_epc (.aclk(aclk), .aresetn(aresetn), .clk_en(ce),
    .s_axil_awaddr(awaddr), .s_axil_awvalid(awvalid), .s_axil_awready(awready),
    .s_axil_wdata(wdata), .s_axil_wstrb(wstrb), .s_axil_wvalid(wvalid),
    .s_axil_wready(wready), .s_axil_bresp(bresp), .s_axil_bvalid(bvalid),
    .s_axil_bready(bready), .s_axil_araddr(araddr), .s_axil_arvalid(arvalid),
    .s_axil_arready(arready), .s_axil_rdata(rdata), .s_axil_rresp(rresp),
    .s_axil_rvalid(rvalid), .s_axil_rready(rready), .exc_valid(e_v), .exc_code(e_code),
    .exc_pc(e_pc), .exc_branch_pc(e_bpc), .exc_in_delay_slot(e_ds),
    .exc_after_extend(e_ext), .exc_isa16(e_i16), .exc_cop_num(e_cop),
    .count_value(cnt), .compare_value(cmpv), .int_req(ireq),
    .compact_isa_enable_pin(pin), .interrupt_request(irq_o), .exception_level(exl_o),
    .compact_isa_enabled(cmp_o));
  pipe_model i_pipe_model (.aclk(aclk), .exc_valid(e_v), .exc_code(e_code), .exc_pc(e_pc),
    .exc_branch_pc(e_bpc), .exc_in_delay_slot(e_ds), .exc_after_extend(e_ext),
    .exc_isa16(e_i16), .exc_cop_num(e_cop), .count_value(cnt), .compare_value(cmpv),
    .int_req(ireq));

  // ----------------------------------------
  // bus and check tasks
  // ----------------------------------------
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    cmp_count++;
    if (s !== e) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic [3:0] s,
                    input logic [1:0] r);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    {awvalid, wvalid, bready} <= 3'h7;
    do begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    bready <= 1'b0;
    chk("bresp", 32'(bresp), 32'(r));
  endtask : wr
  task automatic rd(input logic [31:0] a, input logic [1:0] r);
    @(posedge aclk);
    araddr <= a;
    {arvalid, rready} <= 2'h3;
    do begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rd_v = rdata;
    rready <= 1'b0;
    chk("rresp", 32'(rresp), 32'(r));
  endtask : rd
  task automatic rdc(input string n, input logic [31:0] a, input logic [31:0] m,
                     input logic [31:0] e);
    rd(a, RESP_OKAY);
    chk(n, rd_v & m, e);
  endtask : rdc
  task automatic irq_chk(input logic e);
    repeat (3) @(posedge aclk);
    #1;
    chk("irq", 32'(irq_o), 32'(e));
  endtask : irq_chk
  // clear the levels, report one exception, check code, slot flag and return address
  task automatic exc_case(input logic [4:0] k, input logic [31:0] a, input logic [31:0] b,
                          input logic [2:0] f, input logic s, input logic [31:0] epc_e);
    wr(CTRL_ADDR, 32'h0, 4'hf, RESP_OKAY);
    i_pipe_model.raise(k, a, b, f);
    rdc("cause", CAUSE_ADDR, 32'h8000_007c, {s, 24'h0, k, 2'h0});
    rdc("epc", EPC_ADDR, 32'hffff_ffff, epc_e);
    chk("exl", 32'(exl_o), 32'h1);
  endtask : exc_case
  task automatic rst(input int n);
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (n) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (10) @(posedge aclk);
  endtask : rst
  task automatic wrap_up();
    $display("compares %0d errors %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : wrap_up

  // ----------------------------------------
  // clock, watchdog and tests
  // ----------------------------------------
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  // whole sequence needs about 500 cycles
  initial begin
    #200us;
    error_cnt++;
    wrap_up();
  end
  initial begin
    {awaddr, wdata, araddr, wstrb, awvalid, wvalid, bready, arvalid, rready} = '0;
    {aresetn, pin, ce} = 3'h1;
    rst(20);
    rdc("cause", CAUSE_ADDR, 32'hcfff_ffff, 32'h0);
    rdc("epc", EPC_ADDR, 32'hffff_ffff, EPC_RST);
    rdc("ctrl", CTRL_ADDR, 32'h0000_ff07, 32'h4);
    rdc("info", INFO_ADDR, 32'h3, 32'h0);
    wr(32'h10, 32'h1, 4'hf, RESP_SLVERR);
    rd(32'h10, RESP_SLVERR);
    chk("unmapped", rd_v, 32'h0);
    // every legal code; extend and isa flags must not count in plain mode
    for (int i = 0; i < 15; i++) begin
      c = (i == 14) ? 5'h17 : 5'(i);
      p = 32'h8000_0100 + 32'(i * 16);
      exc_case(c, p, p - 32'h4, 3'h3, 1'b0, p);
      if (c == 5'h0b) rdc("cop", CAUSE_ADDR, 32'h3000_0000, 32'h2000_0000);
    end
    wr(CTRL_ADDR, 32'h0, 4'hf, RESP_OKAY);
    i_pipe_model.raise(5'h0e, 32'h9000_0000, 32'h0, 3'h0);
    i_pipe_model.raise(5'h1f, 32'h9000_0000, 32'h0, 3'h0);
    rdc("code", CAUSE_ADDR, 32'h7c, 32'h5c);
    rdc("epc", EPC_ADDR, 32'hffff_ffff, p);
    chk("exl", 32'(exl_o), 32'h0);
    i_pipe_model.raise(5'h09, 32'ha000_0010, 32'h0, 3'h0);
    i_pipe_model.raise(5'h0c, 32'ha000_0020, 32'h0, 3'h0);
    rdc("code", CAUSE_ADDR, 32'h7c, 32'h30);
    rdc("epc", EPC_ADDR, 32'hffff_ffff, 32'ha000_0010);
    exc_case(5'h0a, 32'hb000_0104, 32'hb000_0100, 3'h4, 1'b1, 32'hb000_0100);
    wr(EPC_ADDR, 32'h1234_5678, 4'hf, RESP_OKAY);
    wr(EPC_ADDR, 32'h0000_00ab, 4'h1, RESP_OKAY);
    rdc("epc", EPC_ADDR, 32'hffff_ffff, 32'h1234_56ab);
    wr(CAUSE_ADDR, 32'hffff_fdff, 4'hf, RESP_OKAY);
    rdc("cause", CAUSE_ADDR, 32'hcfff_ffff, 32'h8000_0128);
    for (int i = 0; i < 5; i++) begin
      wr(CTRL_ADDR, ctl[i], 4'hf, RESP_OKAY);
      irq_chk(i == 0);
    end
    wr(CTRL_ADDR, 32'h8001, 4'hf, RESP_OKAY);
    i_pipe_model.timer(1'b1);
    irq_chk(1'b1);
    rdc("timer", CAUSE_ADDR, 32'h8000, 32'h8000);
    i_pipe_model.timer(1'b0);
    irq_chk(1'b0);
    wr(CAUSE_ADDR, 32'h0, 4'hf, RESP_OKAY);
    rdc("soft", CAUSE_ADDR, 32'h300, 32'h0);
    i_pipe_model.irq(5'h05);
    repeat (6) @(posedge aclk);
    rdc("lines", CAUSE_ADDR, 32'hfc00, 32'h1400);
    i_pipe_model.irq(5'h00);
    // a report while the clock enable is low must leave no trace
    @(posedge aclk);
    ce <= 1'b0;
    i_pipe_model.raise(5'h08, 32'hc000_0000, 32'h0, 3'h0);
    ce <= 1'b1;
    rdc("frozen", CAUSE_ADDR, 32'h7c, 32'h28);
    chk("frozen exl", 32'(exl_o), 32'h0);
    // compact mode needs a fresh reset with the pin high
    @(posedge aclk);
    pin <= 1'b1;
    rst(4);
    chk("compact", 32'(cmp_o), 32'h1);
    rdc("info", INFO_ADDR, 32'h1, 32'h1);
    exc_case(5'h04, 32'h0040_0102, 32'h0040_0100, 3'h3, 1'b1, 32'h0040_0101);
    exc_case(5'h05, 32'h0040_0200, 32'h0040_01fc, 3'h2, 1'b0, 32'h0040_0200);
    exc_case(5'h06, 32'h0040_0302, 32'h0040_0300, 3'h1, 1'b0, 32'h0040_0303);
    exc_case(5'h07, 32'h0040_0404, 32'h0040_0400, 3'h4, 1'b1, 32'h0040_0400);
    wrap_up();
  end
endmodule : exc_cause_epc_bench
